//--- dv/board_pins.sv
// Purpose: Board-side model of the twenty port pins
// Assumes: Device drive wins wherever its enable is low
// Notes: A released pin without pull-up toggles, so stale levels never pass
`timescale 1ns/1ps
`default_nettype none
module board_pins (
    // Clock
    input wire logic clk,
    // Device side
    input wire logic [19:0] pin_out,
    input wire logic [19:0] pin_oe_n,
    input wire logic [19:0] pin_pullup,
    // Board drive
    input wire logic [19:0] drv_en,
    input wire logic [19:0] drv_val,
    // Resolved level
    output logic [19:0] level
);
    logic [19:0] last_q = 20'h00000;
    // ========================================
    // Wire resolution
    always_comb begin
        for (int n = 0; n < 20; n++) begin
            if (!pin_oe_n[n]) level[n] = pin_out[n];
            else if (drv_en[n]) level[n] = drv_val[n];
            else if (pin_pullup[n]) level[n] = 1'b1;
            else level[n] = ~last_q[n];
        end
    end
    // Floating pins flip every cycle
    always @(posedge clk) last_q <= level;
endmodule
`default_nettype wire

//--- dv/tb_twenty_bit_gpio_port.sv
// Purpose: Self-checking bench for the twenty-bit port
// Assumes: Register strobes one cycle wide, answers one cycle later
// Notes: Reads are queued and checked by a separate watcher
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
    begin \
        n_checks++; \
        if ((a) !== (b)) begin \
            n_mismatch++; \
            $display("mismatch at %0t: got %0h expected %0h", $time, a, b); \
        end \
    end
module tb_twenty_bit_gpio_port;
    // ========================================
    // Signals
    logic CLK = 1'b0;
    logic NRST = 1'b0;
    logic [31:0] REG_ADDR = 32'h00000000;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic [1:0] REG_SIZE = 2'h0;
    logic [31:0] REG_WDATA = 32'h00000000;
    logic PORT_USE_SEL = 1'b1;
    logic [31:0] REG_RDATA;
    logic REG_RVALID;
    logic REG_ERR;
    logic [19:0] PIN_IN, PIN_OUT, PIN_OE_N, PIN_PULLUP;
    logic PIN_IRQ;
    logic [19:0] drv_en = 20'hFFFFF;
    logic [19:0] drv_val = 20'hFFFFF;
    int n_mismatch = 0;
    int n_checks = 0;
    logic [32:0] exp_q[$];
    logic [32:0] e;
    logic [31:0] seed = 32'h06C58216;
    logic [31:0] cfg_l = 32'h00000000;
    logic [7:0] cfg_h = 8'h00;
    logic [15:0] lat_l = 16'h0000;
    logic [3:0] lat_h = 4'h0;

    always #12.5 CLK = ~CLK;

    twenty_bit_gpio_port DUT (.CLK(CLK), .NRST(NRST), .REG_ADDR(REG_ADDR),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_SIZE(REG_SIZE),
        .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
        .REG_RVALID(REG_RVALID), .REG_ERR(REG_ERR),
        .PORT_USE_SEL(PORT_USE_SEL), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT),
        .PIN_OE_N(PIN_OE_N), .PIN_PULLUP(PIN_PULLUP), .PIN_IRQ(PIN_IRQ));

    board_pins board (.clk(CLK), .pin_out(PIN_OUT), .pin_oe_n(PIN_OE_N),
        .pin_pullup(PIN_PULLUP), .drv_en(drv_en), .drv_val(drv_val),
        .level(PIN_IN));

    // ========================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h00000000);
    endfunction

    // Field b of every pin: 0 direction, 1 pull-up disable
    function automatic logic [19:0] field(input int b);
        logic [19:0] f;
        for (int n = 0; n < 16; n++) f[n] = cfg_l[2*n+b];
        for (int n = 0; n < 4; n++) f[16+n] = cfg_h[2*n+b];
        return f;
    endfunction

    task automatic access(input logic wr, input logic [31:0] a,
            input logic [1:0] sz, input logic [31:0] d);
        @(posedge CLK);
        REG_ADDR <= a;
        REG_SIZE <= sz;
        REG_WDATA <= d;
        if (wr) REG_WR <= 1'b1;
        else REG_RD <= 1'b1;
        @(posedge CLK);
        REG_WR <= 1'b0;
        REG_RD <= 1'b0;
    endtask

    // Expectation is {error, data}
    task automatic rd(input logic [31:0] a, input logic [1:0] sz,
            input logic [32:0] x);
        exp_q.push_back(x);
        access(1'b0, a, sz, 32'h00000000);
    endtask

    // Pins settle one edge after a write; two more for margin
    task automatic check_pins();
        logic [19:0] on;
        repeat (3) @(posedge CLK);
        @(negedge CLK);
        on = field(0) & {20{PORT_USE_SEL}};
        `CHK(PIN_OE_N, ~on)
        `CHK(PIN_PULLUP, ~field(0) & ~field(1) & {20{PORT_USE_SEL}})
        `CHK(PIN_OUT & on, {lat_h, lat_l} & on)
    endtask

    task automatic config_round();
        logic [19:0] dir;
        seed = lfsr(seed);
        lat_l = seed[15:0];
        lat_h = seed[19:16];
        access(1'b1, gpio_port_pkg::OFS_DATA_LOW16, gpio_port_pkg::SIZE_16,
            {seed[31:16], lat_l});
        access(1'b1, gpio_port_pkg::OFS_DATA_HIGH4, gpio_port_pkg::SIZE_16,
            {seed[11:0], seed[15:0], lat_h});
        seed = lfsr(seed);
        cfg_l = seed;
        access(1'b1, gpio_port_pkg::OFS_CFG_LOW16, gpio_port_pkg::SIZE_32,
            cfg_l);
        seed = lfsr(seed);
        cfg_h = seed[7:0];
        access(1'b1, gpio_port_pkg::OFS_CFG_HIGH4, gpio_port_pkg::SIZE_32,
            seed);
        dir = field(0);
        drv_en <= ~dir;
        drv_val <= seed[27:8];
        check_pins();
        dir = (dir & {lat_h, lat_l}) | (~dir & drv_val);
        rd(gpio_port_pkg::OFS_CFG_LOW16, gpio_port_pkg::SIZE_32,
            {1'b0, cfg_l});
        rd(gpio_port_pkg::OFS_CFG_HIGH4, gpio_port_pkg::SIZE_32,
            {25'h0000000, cfg_h});
        rd(gpio_port_pkg::OFS_DATA_LOW16, gpio_port_pkg::SIZE_16,
            {17'h00000, dir[15:0]});
        rd(gpio_port_pkg::OFS_DATA_HIGH4, gpio_port_pkg::SIZE_16,
            {29'h00000000, dir[19:16]});
    endtask

    task automatic give_verdict();
        if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // ========================================
    // Read watcher, off the launching edge
    always @(negedge CLK) begin
        if (REG_RVALID === 1'b1) begin
            if (exp_q.size() == 0) e = 33'h1FFFFFFFF;
            else e = exp_q.pop_front();
            `CHK({REG_ERR, REG_RDATA}, e)
        end
    end

    // Watchdog, about twenty-five times the expected run
    initial begin
        repeat (6000) @(posedge CLK);
        n_mismatch++;
        give_verdict();
    end

    // ========================================
    // Main sequence
    initial begin
        repeat (10) @(posedge CLK);
        NRST <= 1'b1;
        rd(gpio_port_pkg::OFS_CFG_LOW16, gpio_port_pkg::SIZE_32, 33'h0);
        rd(gpio_port_pkg::OFS_CFG_HIGH4, gpio_port_pkg::SIZE_32, 33'h0);
        rd(gpio_port_pkg::OFS_PIN_IRQ_CTRL, gpio_port_pkg::SIZE_16, 33'h0);
        check_pins();
        repeat (8) config_round();
        // Refused sizes and an unmapped place
        access(1'b1, gpio_port_pkg::OFS_CFG_LOW16, gpio_port_pkg::SIZE_16,
            32'hFFFFFFFF);
        @(negedge CLK);
        `CHK(REG_ERR, 1'b1)
        access(1'b1, gpio_port_pkg::OFS_DATA_LOW16, gpio_port_pkg::SIZE_8,
            32'hFFFFFFFF);
        @(negedge CLK);
        `CHK(REG_ERR, 1'b1)
        rd(gpio_port_pkg::OFS_CFG_LOW16, gpio_port_pkg::SIZE_16,
            {1'b1, 32'h00000000});
        rd(gpio_port_pkg::OFS_DATA_LOW16, gpio_port_pkg::SIZE_32,
            {1'b1, 32'h00000000});
        rd(gpio_port_pkg::OFS_CFG_LOW16, gpio_port_pkg::SIZE_32,
            {1'b0, cfg_l});
        rd(32'hFF80004C, gpio_port_pkg::SIZE_32, 33'h0);
        // Interrupt: all inputs, pin 3 enabled
        cfg_l = 32'h00000000;
        cfg_h = 8'h00;
        access(1'b1, gpio_port_pkg::OFS_CFG_LOW16, gpio_port_pkg::SIZE_32,
            cfg_l);
        access(1'b1, gpio_port_pkg::OFS_CFG_HIGH4, gpio_port_pkg::SIZE_32,
            32'h00000000);
        drv_en <= 20'hFFFFF;
        drv_val <= 20'hFFFFF;
        access(1'b1, gpio_port_pkg::OFS_PIN_IRQ_CTRL, gpio_port_pkg::SIZE_16,
            32'h00000008);
        rd(gpio_port_pkg::OFS_PIN_IRQ_CTRL, gpio_port_pkg::SIZE_16,
            33'h000000008);
        @(posedge CLK);
        drv_val <= 20'hFFFF7;
        @(negedge CLK);
        `CHK(PIN_IRQ, 1'b0)
        @(negedge CLK);
        `CHK(PIN_IRQ, 1'b1)
        @(posedge CLK);
        drv_val <= 20'hFFFEF;
        repeat (2) @(negedge CLK);
        `CHK(PIN_IRQ, 1'b0)
        @(posedge CLK);
        drv_val <= 20'h00000;
        PORT_USE_SEL <= 1'b0;
        check_pins();
        `CHK(PIN_IRQ, 1'b0)
        @(posedge CLK);
        PORT_USE_SEL <= 1'b1;
        repeat (2) @(negedge CLK);
        `CHK(PIN_IRQ, 1'b1)
        // Power-on reset in mid-run keeps the data latches
        @(posedge CLK);
        NRST <= 1'b0;
        repeat (2) @(posedge CLK);
        NRST <= 1'b1;
        rd(gpio_port_pkg::OFS_CFG_LOW16, gpio_port_pkg::SIZE_32, 33'h0);
        rd(gpio_port_pkg::OFS_CFG_HIGH4, gpio_port_pkg::SIZE_32, 33'h0);
        rd(gpio_port_pkg::OFS_PIN_IRQ_CTRL, gpio_port_pkg::SIZE_16, 33'h0);
        check_pins();
        `CHK(PIN_IRQ, 1'b0)
        cfg_l = 32'h55555555;
        cfg_h = 8'h55;
        access(1'b1, gpio_port_pkg::OFS_CFG_LOW16, gpio_port_pkg::SIZE_32,
            cfg_l);
        access(1'b1, gpio_port_pkg::OFS_CFG_HIGH4, gpio_port_pkg::SIZE_32,
            32'h00000055);
        drv_en <= 20'h00000;
        check_pins();
        rd(gpio_port_pkg::OFS_DATA_LOW16, gpio_port_pkg::SIZE_16,
            {17'h00000, lat_l});
        rd(gpio_port_pkg::OFS_DATA_HIGH4, gpio_port_pkg::SIZE_16,
            {29'h00000000, lat_h});
        repeat (4) @(negedge CLK);
        `CHK(exp_q.size(), 0)
        give_verdict();
    end
endmodule
`default_nettype wire

//--- rtl/gpio_port_pkg.sv
// Purpose: Shared constants for the twenty-bit general-purpose port
// Assumes: Memory-mapped register access at the printed addresses
// Notes: Field layout is two bits per pin, pull-up above direction
package gpio_port_pkg;
    // ========================================
    // Register addresses
    localparam logic [31:0] OFS_CFG_LOW16 = 32'hFF80002C;
    localparam logic [31:0] OFS_DATA_LOW16 = 32'hFF800030;
    localparam logic [31:0] OFS_CFG_HIGH4 = 32'hFF800040;
    localparam logic [31:0] OFS_DATA_HIGH4 = 32'hFF800044;
    localparam logic [31:0] OFS_PIN_IRQ_CTRL = 32'hFF800048;
    // ========================================
    // Group widths and field layout
    localparam int LOW_PINS = 16;
    localparam int HIGH_PINS = 4;
    localparam int ALL_PINS = 20;
    localparam int FIELD_W = 2;
    localparam int DIR_POS = 0;
    localparam int PUD_POS = 1;
    localparam int HIGH_CFG_W = 8;
    // ========================================
    // Reset values and access sizes
    localparam logic [31:0] CFG_LOW_RST = 32'h00000000;
    localparam logic [7:0] CFG_HIGH_RST = 8'h00;
    localparam logic [15:0] IRQ_CTRL_RST = 16'h0000;
    localparam logic [31:0] RDATA_RST = 32'h00000000;
    localparam logic [1:0] SIZE_8 = 2'h0;
    localparam logic [1:0] SIZE_16 = 2'h1;
    localparam logic [1:0] SIZE_32 = 2'h2;
    localparam logic [15:0] ZERO_16 = 16'h0000;
    localparam logic [23:0] ZERO_24 = 24'h000000;
    localparam logic [11:0] ZERO_12 = 12'h000;
endpackage

//--- rtl/pin_group.sv
// Purpose: Pin drivers, pull-up control and readback for one port group
// Assumes: Pin inputs synchronous to clk
// Notes: Output latch itself lives in the register file above
`timescale 1ns/1ps
`default_nettype none
module pin_group #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Configuration
    input wire logic [2*W-1:0] cfg,
    input wire logic [W-1:0] latch,
    input wire logic use_sel,
    // Pins
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_out,
    output logic [W-1:0] pin_oe_n,
    output logic [W-1:0] pull_en,
    // Readback
    output logic [W-1:0] dir,
    output logic [W-1:0] rd_val
);
    // ========================================
    // Field decode
    logic [W-1:0] pud;
    logic [W-1:0] out_q;
    logic [W-1:0] oe_n_q;
    logic [W-1:0] pull_q;
    logic [W-1:0] smp_q;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_pin
            assign dir[i] = cfg[i*gpio_port_pkg::FIELD_W + gpio_port_pkg::DIR_POS];
            assign pud[i] = cfg[i*gpio_port_pkg::FIELD_W + gpio_port_pkg::PUD_POS];
        end
    endgenerate

    // ========================================
    // Pin drivers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            oe_n_q <= '1;
        end else begin
            oe_n_q <= ~(dir & {W{use_sel}});
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            out_q <= '0;
        end else begin
            out_q <= latch & dir;
        end
    end

    // Pull-up never fights an output driver
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pull_q <= '0;
        end else begin
            pull_q <= ~pud & ~dir & {W{use_sel}};
        end
    end

    // ========================================
    // Input sampling and readback
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            smp_q <= '0;
        end else begin
            smp_q <= pin_in;
        end
    end

    assign rd_val = (dir & latch) | (~dir & smp_q);
    assign pin_out = out_q;
    assign pin_oe_n = oe_n_q;
    assign pull_en = pull_q;

    // ========================================
    // Checks
    property p_pull_off_out;
        @(posedge clk) disable iff (!nrst)
        1 |=> ((pull_q & $past(dir)) == '0);
    endproperty
    a_pull_off_out: assert property (p_pull_off_out)
        else $error("pull-up on an output pin");

    property p_pull_sel;
        @(posedge clk) disable iff (!nrst)
        $past(nrst) |-> (pull_q == $past(~pud & ~dir & {W{use_sel}}));
    endproperty
    a_pull_sel: assert property (p_pull_sel)
        else $error("pull-up does not follow its field");

    property p_no_drive_in;
        @(posedge clk) disable iff (!nrst)
        1 |=> ((~oe_n_q & ~$past(dir)) == '0);
    endproperty
    a_no_drive_in: assert property (p_no_drive_in)
        else $error("input pin is driven");

    property p_drive_val;
        @(posedge clk) disable iff (!nrst)
        1 |=> (((out_q ^ $past(latch)) & ~oe_n_q) == '0);
    endproperty
    a_drive_val: assert property (p_drive_val)
        else $error("driven level differs from latch");

    property p_rd_in;
        @(posedge clk) disable iff (!nrst)
        $past(nrst) |-> (((rd_val ^ $past(pin_in)) & ~dir) == '0);
    endproperty
    a_rd_in: assert property (p_rd_in)
        else $error("input readback is not the sampled pin");

    c_out_driven: cover property (@(posedge clk) disable iff (!nrst)
        (~oe_n_q != '0));
endmodule
`default_nettype wire

//--- rtl/twenty_bit_gpio_port.sv
// Purpose: Twenty-bit general-purpose port with pull-up and pin interrupt
// Assumes: NRST is the power-on reset; manual reset and standby keep state
// Notes: Reads answer one cycle after the strobe, with REG_RVALID
`timescale 1ns/1ps
`default_nettype none
module twenty_bit_gpio_port (
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Register access
    input wire logic [31:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [1:0] REG_SIZE,
    input wire logic [31:0] REG_WDATA,
    output logic [31:0] REG_RDATA,
    output logic REG_RVALID,
    output logic REG_ERR,
    // Port use select from bus control
    input wire logic PORT_USE_SEL,
    // Pins
    input wire logic [19:0] PIN_IN,
    output logic [19:0] PIN_OUT,
    output logic [19:0] PIN_OE_N,
    output logic [19:0] PIN_PULLUP,
    output logic PIN_IRQ
);
    // ========================================
    // Decode helpers
    function automatic logic hit(input logic [31:0] a, input logic [31:0] o);
        hit = (a == o);
    endfunction

    function automatic logic is_cfg(input logic [31:0] a);
        is_cfg = hit(a, gpio_port_pkg::OFS_CFG_LOW16) |
                 hit(a, gpio_port_pkg::OFS_CFG_HIGH4);
    endfunction

    function automatic logic mapped(input logic [31:0] a);
        mapped = is_cfg(a) | hit(a, gpio_port_pkg::OFS_DATA_LOW16) |
                 hit(a, gpio_port_pkg::OFS_DATA_HIGH4) |
                 hit(a, gpio_port_pkg::OFS_PIN_IRQ_CTRL);
    endfunction

    // Config wants a full word, the rest a halfword
    function automatic logic size_ok(input logic [31:0] a,
                                     input logic [1:0] s);
        if (is_cfg(a)) begin
            size_ok = (s == gpio_port_pkg::SIZE_32);
        end else begin
            size_ok = (s == gpio_port_pkg::SIZE_16);
        end
    endfunction

    // ========================================
    // State
    logic [31:0] cfg_low_q;
    logic [7:0] cfg_high_q;
    logic [15:0] latch_low_q;
    logic [3:0] latch_high_q;
    logic [15:0] irq_en_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic rvalid_q;
    logic err_q;
    logic irq_q;
    logic wr_ok;
    logic acc_bad;
    logic [15:0] rd_low;
    logic [3:0] rd_high;
    logic [15:0] dir_low;
    logic [3:0] dir_high;

    assign wr_ok = REG_WR & mapped(REG_ADDR) & size_ok(REG_ADDR, REG_SIZE);
    assign acc_bad = (REG_WR | REG_RD) & mapped(REG_ADDR) &
                     ~size_ok(REG_ADDR, REG_SIZE);

    // ========================================
    // Configuration registers
    // Only power-on reset reaches these; no manual reset input exists
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            cfg_low_q <= gpio_port_pkg::CFG_LOW_RST;
        end else if (wr_ok && hit(REG_ADDR, gpio_port_pkg::OFS_CFG_LOW16)) begin
            cfg_low_q <= REG_WDATA;
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            cfg_high_q <= gpio_port_pkg::CFG_HIGH_RST;
        end else if (wr_ok && hit(REG_ADDR, gpio_port_pkg::OFS_CFG_HIGH4)) begin
            cfg_high_q <= REG_WDATA[gpio_port_pkg::HIGH_CFG_W-1:0];
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            irq_en_q <= gpio_port_pkg::IRQ_CTRL_RST;
        end else if (wr_ok && hit(REG_ADDR, gpio_port_pkg::OFS_PIN_IRQ_CTRL)) begin
            irq_en_q <= REG_WDATA[15:0];
        end
    end

    // ========================================
    // Data latches
    // No reset on purpose: contents survive every reset kind
    always_ff @(posedge CLK) begin
        if (wr_ok && hit(REG_ADDR, gpio_port_pkg::OFS_DATA_LOW16)) begin
            latch_low_q <= REG_WDATA[15:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (wr_ok && hit(REG_ADDR, gpio_port_pkg::OFS_DATA_HIGH4)) begin
            latch_high_q <= REG_WDATA[3:0];
        end
    end

    // ========================================
    // Pin groups
    pin_group #(
        .W(gpio_port_pkg::LOW_PINS)
    ) u_low (
        .clk(CLK),
        .nrst(NRST),
        .cfg(cfg_low_q),
        .latch(latch_low_q),
        .use_sel(PORT_USE_SEL),
        .pin_in(PIN_IN[15:0]),
        .pin_out(PIN_OUT[15:0]),
        .pin_oe_n(PIN_OE_N[15:0]),
        .pull_en(PIN_PULLUP[15:0]),
        .dir(dir_low),
        .rd_val(rd_low)
    );

    pin_group #(
        .W(gpio_port_pkg::HIGH_PINS)
    ) u_high (
        .clk(CLK),
        .nrst(NRST),
        .cfg(cfg_high_q),
        .latch(latch_high_q),
        .use_sel(PORT_USE_SEL),
        .pin_in(PIN_IN[19:16]),
        .pin_out(PIN_OUT[19:16]),
        .pin_oe_n(PIN_OE_N[19:16]),
        .pull_en(PIN_PULLUP[19:16]),
        .dir(dir_high),
        .rd_val(rd_high)
    );

    // ========================================
    // Read path
    always_comb begin
        rdata_d = gpio_port_pkg::RDATA_RST;
        if (REG_RD && size_ok(REG_ADDR, REG_SIZE)) begin
            if (hit(REG_ADDR, gpio_port_pkg::OFS_CFG_LOW16)) begin
                rdata_d = cfg_low_q;
            end else if (hit(REG_ADDR, gpio_port_pkg::OFS_CFG_HIGH4)) begin
                rdata_d = {gpio_port_pkg::ZERO_24, cfg_high_q};
            end else if (hit(REG_ADDR, gpio_port_pkg::OFS_DATA_LOW16)) begin
                rdata_d = {gpio_port_pkg::ZERO_16, rd_low};
            end else if (hit(REG_ADDR, gpio_port_pkg::OFS_DATA_HIGH4)) begin
                rdata_d = {gpio_port_pkg::ZERO_16, gpio_port_pkg::ZERO_12,
                           rd_high};
            end else if (hit(REG_ADDR, gpio_port_pkg::OFS_PIN_IRQ_CTRL)) begin
                rdata_d = {gpio_port_pkg::ZERO_16, irq_en_q};
            end
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rdata_q <= gpio_port_pkg::RDATA_RST;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= REG_RD;
        end
    end

    // Wrong access size is dropped and flagged
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            err_q <= 1'b0;
        end else begin
            err_q <= acc_bad;
        end
    end

    // ========================================
    // Pin interrupt
    // Level only: stays up while any enabled pin is held low and PORT_USE_SEL is high
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= PORT_USE_SEL & |(irq_en_q & ~PIN_IN[15:0]);
        end
    end

    assign REG_RDATA = rdata_q;
    assign REG_RVALID = rvalid_q;
    assign REG_ERR = err_q;
    assign PIN_IRQ = irq_q;

    // ========================================
    // Checks
    property p_cfg_rst;
        @(posedge CLK) disable iff (!NRST)
        $rose(NRST) |-> (cfg_low_q == gpio_port_pkg::CFG_LOW_RST) &&
                        (cfg_high_q == gpio_port_pkg::CFG_HIGH_RST);
    endproperty
    a_cfg_rst: assert property (p_cfg_rst)
        else $error("configuration not cleared by reset");

    property p_high_cfg_zero;
        @(posedge CLK) disable iff (!NRST)
        REG_RD && size_ok(REG_ADDR, REG_SIZE) &&
        hit(REG_ADDR, gpio_port_pkg::OFS_CFG_HIGH4) |=>
            (REG_RDATA[31:8] == gpio_port_pkg::ZERO_24) &&
            (REG_RDATA[7:0] == $past(cfg_high_q));
    endproperty
    a_high_cfg_zero: assert property (p_high_cfg_zero)
        else $error("high configuration readback wrong");

    property p_rd_out;
        @(posedge CLK) disable iff (!NRST)
        REG_RD && size_ok(REG_ADDR, REG_SIZE) &&
        hit(REG_ADDR, gpio_port_pkg::OFS_DATA_LOW16) |=>
            ((REG_RDATA[15:0] & $past(dir_low)) ==
             ($past(latch_low_q) & $past(dir_low)));
    endproperty
    a_rd_out: assert property (p_rd_out)
        else $error("output readback is not the latch");

    property p_cfg_size;
        @(posedge CLK) disable iff (!NRST)
        REG_WR && hit(REG_ADDR, gpio_port_pkg::OFS_CFG_LOW16) &&
        (REG_SIZE != gpio_port_pkg::SIZE_32) |=>
            $stable(cfg_low_q) && REG_ERR;
    endproperty
    a_cfg_size: assert property (p_cfg_size)
        else $error("narrow configuration write was taken");

    property p_irq;
        @(posedge CLK) disable iff (!NRST)
        1 |=> (PIN_IRQ == ($past(PORT_USE_SEL) &&
                           (($past(irq_en_q) & ~$past(PIN_IN[15:0])) != 0)));
    endproperty
    a_irq: assert property (p_irq)
        else $error("pin interrupt does not follow enabled pins");

    property p_unused;
        @(posedge CLK) disable iff (!NRST)
        !PORT_USE_SEL |=> (PIN_OE_N == '1) && (PIN_PULLUP == '0);
    endproperty
    a_unused: assert property (p_unused)
        else $error("unused port still drives or pulls");

    property p_dir_high;
        @(posedge CLK) disable iff (!NRST)
        PORT_USE_SEL |=> (~PIN_OE_N[19:16] == $past(dir_high));
    endproperty
    a_dir_high: assert property (p_dir_high)
        else $error("high group driver does not follow direction");

    property p_dir_low;
        @(posedge CLK) disable iff (!NRST)
        PORT_USE_SEL |=> (~PIN_OE_N[15:0] == $past(dir_low));
    endproperty
    a_dir_low: assert property (p_dir_low)
        else $error("low group driver does not follow direction");

    c_read_data: cover property (@(posedge CLK) disable iff (!NRST)
        REG_RD && hit(REG_ADDR, gpio_port_pkg::OFS_DATA_LOW16) ##1 REG_RVALID);
    c_irq: cover property (@(posedge CLK) disable iff (!NRST) $rose(PIN_IRQ));
    c_err: cover property (@(posedge CLK) disable iff (!NRST) REG_ERR);
endmodule
`default_nettype wire
